// *** core/lcd_supply_pkg.sv ***
// constants for the lcd supply and reset control block
package lcd_supply_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam int CLK_FREQ_KHZ = 10000;
   localparam int STARTUP_TIME_US = 1000;
   localparam int STARTUP_CYCLES = (STARTUP_TIME_US * CLK_FREQ_KHZ) / 1000;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] VPROG_OFS = 4'h1;
   localparam logic [3:0] MUX_OFS = 4'h2;
   localparam logic [3:0] STATUS_OFS = 4'h3;
   localparam logic [3:0] TARGET_OFS = 4'h4;
   localparam logic [3:0] GEOM_OFS = 4'h5;

   // ****************************************
   // control register fields
   // ****************************************
   localparam int PUMP_ON_POS = 0;
   localparam int PUMP_MULT_POS = 1;
   localparam int TEMP_COMP_POS = 2;
   localparam int DISP_ON_POS = 3;
   localparam int EXT_SUPPLY_POS = 4;

   // ****************************************
   // status register fields
   // ****************************************
   localparam int READY_POS = 0;
   localparam int CLAMP_POS = 1;
   localparam int GEN_ON_POS = 2;

   // ****************************************
   // values after reset
   // ****************************************
   localparam logic PUMP_ON_RST = 1'b0;
   localparam logic PUMP_MULT_RST = 1'b0;
   localparam logic TEMP_COMP_RST = 1'b1;
   localparam logic DISP_ON_RST = 1'b0;
   localparam logic EXT_SUPPLY_RST = 1'b0;
   localparam logic [7:0] VPROG_RST = 8'h00;

   // ****************************************
   // backplane modes and geometry
   // ****************************************
   typedef enum logic [2:0] {
      MUX_8 = 3'b000,
      MUX_1 = 3'b001,
      MUX_2 = 3'b010,
      MUX_4 = 3'b011,
      MUX_6 = 3'b100
   } mux_mode_type;

   localparam logic [2:0] MUX_RST = 3'b000;
   localparam logic [5:0] SEG_COUNT_STD = 6'h2c;
   localparam logic [5:0] SEG_COUNT_MUX6 = 6'h2e;

endpackage : lcd_supply_pkg

// *** core/lcd_drive_voltage_sat_add.sv ***
// saturating sum of programmed code and signed offset, with upper limit
`timescale 1ns/1ps
module lcd_drive_voltage_sat_add
   import lcd_supply_pkg::*;
#(
   parameter logic [7:0] MAX_CODE = 8'he0
) (
   // operands
   input wire logic [7:0] code_in,
   input wire logic signed [7:0] offset_in,
   // result
   output logic [7:0] sum_out,
   output logic clamped
);

   logic signed [9:0] raw;

   always_comb begin
      raw = $signed({2'b00, code_in}) + 10'(offset_in);
      clamped = 1'b0;
      if (raw < 10'sd0) begin
         sum_out = 8'h00;
         clamped = 1'b1;
      end else if (raw > $signed({2'b00, MAX_CODE})) begin
         sum_out = MAX_CODE;
         clamped = 1'b1;
      end else begin
         sum_out = raw[7:0];
      end
   end

endmodule : lcd_drive_voltage_sat_add

// *** core/lcd_supply_reset_control.sv ***
// reset, supply sequencing and lcd voltage target control
`timescale 1ns/1ps

module lcd_supply_reset_control
   import lcd_supply_pkg::*;
#(
   parameter int STARTUP_COUNT = STARTUP_CYCLES,
   parameter logic [7:0] MAX_CODE = 8'he0
) (
   // clock and resets
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic reset_pin_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // temperature compensation result
   input wire logic signed [7:0] temp_offset_value,
   // supply and display controls
   output logic pump_on_bit,
   output logic pump_multiplier_select,
   output logic lcd_drive_voltage_gen_on,
   output logic [7:0] lcd_drive_voltage,
   output logic display_on,
   output logic config_reset,
   // panel geometry
   output logic [3:0] backplane_count,
   output logic [5:0] segment_count
);

   // ****************************************
   // reset pin synchroniser
   // ****************************************
   logic pin_meta_r;
   logic pin_sync_r;
   logic pin_meta_nxt;
   logic pin_sync_nxt;
   logic cfg_rst;

   always_comb begin
      pin_meta_nxt = reset_pin_n;
      pin_sync_nxt = pin_meta_r;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_meta_r <= 1'b0;
         pin_sync_r <= 1'b0;
      end else begin
         pin_meta_r <= pin_meta_nxt;
         pin_sync_r <= pin_sync_nxt;
      end
   end

   // one reset for all configuration, pin and power-on alike
   assign cfg_rst = rst | ~pin_sync_r;
   // display memory lives outside and is not wired to this reset
   assign config_reset = cfg_rst;

   // ****************************************
   // startup wait after reset release
   // ****************************************
   localparam int CNT_W = $clog2(STARTUP_COUNT + 1);
   localparam logic [CNT_W-1:0] CNT_END = CNT_W'(STARTUP_COUNT);

   logic [CNT_W-1:0] wait_cnt_r;
   logic [CNT_W-1:0] wait_cnt_nxt;
   logic ready_r;
   logic ready_nxt;

   always_comb begin
      wait_cnt_nxt = wait_cnt_r;
      ready_nxt = ready_r;
      if (!ready_r) begin
         if (wait_cnt_r == CNT_END) begin
            ready_nxt = 1'b1;
         end else begin
            wait_cnt_nxt = wait_cnt_r + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (cfg_rst) begin
         wait_cnt_r <= '0;
         ready_r <= 1'b0;
      end else begin
         wait_cnt_r <= wait_cnt_nxt;
         ready_r <= ready_nxt;
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   logic pump_on_r;
   logic pump_mult_r;
   logic temp_comp_r;
   logic disp_on_r;
   logic ext_supply_r;
   logic [7:0] vprog_r;
   mux_mode_type mux_r;
   logic pump_on_nxt;
   logic pump_mult_nxt;
   logic temp_comp_nxt;
   logic disp_on_nxt;
   logic ext_supply_nxt;
   logic [7:0] vprog_nxt;
   mux_mode_type mux_nxt;
   logic mux_legal;

   always_comb begin
      case (reg_wdata[2:0])
         MUX_8, MUX_1, MUX_2, MUX_4, MUX_6: begin
            mux_legal = 1'b1;
         end
         default: begin
            mux_legal = 1'b0;
         end
      endcase
   end

   always_comb begin
      pump_on_nxt = pump_on_r;
      pump_mult_nxt = pump_mult_r;
      temp_comp_nxt = temp_comp_r;
      disp_on_nxt = disp_on_r;
      ext_supply_nxt = ext_supply_r;
      vprog_nxt = vprog_r;
      mux_nxt = mux_r;
      if (reg_wr) begin
         case (reg_addr)
            CTRL_OFS: begin
               pump_on_nxt = reg_wdata[PUMP_ON_POS];
               pump_mult_nxt = reg_wdata[PUMP_MULT_POS];
               temp_comp_nxt = reg_wdata[TEMP_COMP_POS];
               disp_on_nxt = reg_wdata[DISP_ON_POS];
               ext_supply_nxt = reg_wdata[EXT_SUPPLY_POS];
            end
            VPROG_OFS: begin
               vprog_nxt = reg_wdata;
            end
            MUX_OFS: begin
               // unsupported backplane counts leave the mode unchanged
               if (mux_legal) begin
                  mux_nxt = mux_mode_type'(reg_wdata[2:0]);
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (cfg_rst) begin
         pump_on_r <= PUMP_ON_RST;
         pump_mult_r <= PUMP_MULT_RST;
         temp_comp_r <= TEMP_COMP_RST;
         disp_on_r <= DISP_ON_RST;
         ext_supply_r <= EXT_SUPPLY_RST;
         vprog_r <= VPROG_RST;
         mux_r <= mux_mode_type'(MUX_RST);
      end else begin
         pump_on_r <= pump_on_nxt;
         pump_mult_r <= pump_mult_nxt;
         temp_comp_r <= temp_comp_nxt;
         disp_on_r <= disp_on_nxt;
         ext_supply_r <= ext_supply_nxt;
         vprog_r <= vprog_nxt;
         mux_r <= mux_nxt;
      end
   end

   // ****************************************
   // lcd voltage target
   // ****************************************
   logic signed [7:0] offset_used;
   logic [7:0] target_sum;
   logic target_clamped;
   logic [7:0] target_r;
   logic [7:0] target_nxt;
   logic clamp_r;
   logic clamp_nxt;
   logic gen_on_r;
   logic gen_on_nxt;

   // compensation only for internal generation with the enable set
   assign offset_used = (temp_comp_r && !ext_supply_r) ?
      temp_offset_value : 8'sh00;

   lcd_drive_voltage_sat_add #(
      .MAX_CODE(MAX_CODE)
   ) u_sat_add (
      .code_in(vprog_r),
      .offset_in(offset_used),
      .sum_out(target_sum),
      .clamped(target_clamped)
   );

   always_comb begin
      gen_on_nxt = pump_on_r & ~ext_supply_r;
      if (ext_supply_r) begin
         // external supply: programmed code is not passed on
         target_nxt = 8'h00;
         clamp_nxt = 1'b0;
      end else begin
         target_nxt = target_sum;
         clamp_nxt = target_clamped;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (cfg_rst) begin
         target_r <= 8'h00;
         clamp_r <= 1'b0;
         gen_on_r <= 1'b0;
      end else begin
         target_r <= target_nxt;
         clamp_r <= clamp_nxt;
         gen_on_r <= gen_on_nxt;
      end
   end

   // ****************************************
   // panel geometry
   // ****************************************
   logic [3:0] bp_cnt;
   logic [5:0] seg_cnt;

   always_comb begin
      seg_cnt = SEG_COUNT_STD;
      case (mux_r)
         MUX_1: begin
            bp_cnt = 4'h1;
         end
         MUX_2: begin
            bp_cnt = 4'h2;
         end
         MUX_4: begin
            bp_cnt = 4'h4;
         end
         MUX_6: begin
            bp_cnt = 4'h6;
            seg_cnt = SEG_COUNT_MUX6;
         end
         default: begin
            bp_cnt = 4'h8;
         end
      endcase
   end

   // ****************************************
   // read data
   // ****************************************
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            CTRL_OFS: begin
               rdata_nxt[PUMP_ON_POS] = pump_on_r;
               rdata_nxt[PUMP_MULT_POS] = pump_mult_r;
               rdata_nxt[TEMP_COMP_POS] = temp_comp_r;
               rdata_nxt[DISP_ON_POS] = disp_on_r;
               rdata_nxt[EXT_SUPPLY_POS] = ext_supply_r;
            end
            VPROG_OFS: begin
               rdata_nxt = vprog_r;
            end
            MUX_OFS: begin
               rdata_nxt[2:0] = mux_r;
            end
            STATUS_OFS: begin
               rdata_nxt[READY_POS] = ready_r;
               rdata_nxt[CLAMP_POS] = clamp_r;
               rdata_nxt[GEN_ON_POS] = gen_on_r;
            end
            TARGET_OFS: begin
               rdata_nxt = target_r;
            end
            GEOM_OFS: begin
               rdata_nxt = {2'b00, seg_cnt};
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata = rdata_r;
   assign pump_on_bit = pump_on_r;
   assign pump_multiplier_select = pump_mult_r;
   assign lcd_drive_voltage_gen_on = gen_on_r;
   assign lcd_drive_voltage = target_r;
   assign display_on = disp_on_r;
   assign backplane_count = bp_cnt;
   assign segment_count = seg_cnt;

endmodule : lcd_supply_reset_control

// *** sim/temp_offset_src.sv ***
// temperature offset source standing in for the compensation logic
`timescale 1ns/1ps
module temp_offset_src (
   // clock
   input wire logic sys_clk,
   // requested offset
   input wire logic signed [7:0] want_off,
   // offset to the block
   output logic signed [7:0] temp_offset_value
);
   always_ff @(posedge sys_clk) begin
      temp_offset_value <= want_off;
   end
endmodule : temp_offset_src

// *** sim/lcd_supply_reset_control_assertions.sv ***
// port checker for the lcd supply and reset control block
`timescale 1ns/1ps
module lcd_ctl_chk
   import lcd_supply_pkg::*;
#(
   parameter logic [7:0] MAX_CODE = 8'he0
) (
   // clock and resets
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic reset_pin_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // offset
   input wire logic signed [7:0] temp_offset_value,
   // controls
   input wire logic pump_on_bit,
   input wire logic pump_multiplier_select,
   input wire logic lcd_drive_voltage_gen_on,
   input wire logic [7:0] lcd_drive_voltage,
   input wire logic display_on,
   input wire logic config_reset,
   // geometry
   input wire logic [3:0] backplane_count,
   input wire logic [5:0] segment_count
);
   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire ctrl_wr = reg_wr && reg_addr == CTRL_OFS;
   reset_outputs_a: assert property (config_reset |=>
      !pump_on_bit && !display_on && !pump_multiplier_select)
      else $error("outputs not cleared by reset");
   reset_gen_a: assert property (config_reset [*2] |=> !lcd_drive_voltage_gen_on)
      else $error("generation on during reset");
   pin_sync_a: assert property (!reset_pin_n [*2] |=> config_reset)
      else $error("pin reset not taken");
   seg_geom_a: assert property (segment_count ==
      (backplane_count == 4'h6 ? 6'h2e : 6'h2c))
      else $error("segment count wrong");
   bp_legal_a: assert property (backplane_count inside
      {4'h1, 4'h2, 4'h4, 4'h6, 4'h8}) else $error("bad backplanes");
   target_limit_a: assert property (lcd_drive_voltage <= MAX_CODE)
      else $error("target above limit");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   mult_hold_a: assert property ($changed(pump_multiplier_select)
      |-> $past(ctrl_wr) || $past(config_reset))
      else $error("multiplier changed without cause");
   disp_hold_a: assert property ($changed(display_on)
      |-> $past(ctrl_wr) || $past(config_reset))
      else $error("display changed without cause");
   cov_pin: cover property (!reset_pin_n [*2]);
   cov_clamp: cover property (lcd_drive_voltage == MAX_CODE);
   cov_disp: cover property (display_on && lcd_drive_voltage_gen_on);
endmodule : lcd_ctl_chk

bind lcd_supply_reset_control lcd_ctl_chk #(.MAX_CODE(MAX_CODE)) chk_i (.*);

// *** sim/tb_lcd_supply_reset_control.sv ***
// testbench for the lcd supply and reset control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   n_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_lcd_supply_reset_control
   import lcd_supply_pkg::*;
;
   localparam logic [7:0] MC = 8'he0;
   logic sys_clk = 0, rst = 1, reset_pin_n = 1, reg_wr = 0, reg_rd = 0;
   logic [3:0] reg_addr = 0, backplane_count;
   logic [7:0] reg_wdata = 0, reg_rdata, lcd_drive_voltage, v, e, e_r;
   logic signed [7:0] temp_offset_value, o, want_off = 0;
   logic pump_on_bit, pump_multiplier_select, lcd_drive_voltage_gen_on, display_on;
   logic config_reset, c, k, rd_d = 0;
   logic [5:0] segment_count;
   logic [3:0] bp_tab [5] = '{4'h8, 4'h1, 4'h2, 4'h4, 4'h6};
   logic [7:0] exp_q [$];
   int n_errors = 0, checks_done = 0, cyc = 0;
   lcd_supply_reset_control #(.STARTUP_COUNT(8), .MAX_CODE(MC))
      lcd_supply_reset_control_i (.sys_clk(sys_clk), .rst(rst),
      .reset_pin_n(reset_pin_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .temp_offset_value(temp_offset_value),
      .pump_on_bit(pump_on_bit),
      .pump_multiplier_select(pump_multiplier_select),
      .lcd_drive_voltage_gen_on(lcd_drive_voltage_gen_on), .lcd_drive_voltage(lcd_drive_voltage),
      .display_on(display_on), .config_reset(config_reset),
      .backplane_count(backplane_count), .segment_count(segment_count));
   temp_offset_src temp_offset_src_i (.sys_clk(sys_clk),
      .want_off(want_off), .temp_offset_value(temp_offset_value));
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   // ****************************************
   // bus tasks and checks
   // ****************************************
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] x);
      @(posedge sys_clk);
      reg_rd <= 1'b1; reg_addr <= a; exp_q.push_back(x);
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   endtask : rd
   function automatic logic [7:0] sat(logic [7:0] a, logic signed [7:0] b);
      int s;
      s = int'(a) + int'(b);
      if (s < 0) s = 0;
      if (s > int'(MC)) s = int'(MC);
      return s[7:0];
   endfunction : sat
   task chk_rst();
      `CHK("pump", 1'b0, pump_on_bit)
      `CHK("mult", 1'b0, pump_multiplier_select)
      `CHK("gen", 1'b0, lcd_drive_voltage_gen_on)
      `CHK("lcd_drive_voltage", 8'h00, lcd_drive_voltage)
      `CHK("disp", 1'b0, display_on)
      `CHK("bp", 4'h8, backplane_count)
      `CHK("seg", 6'h2c, segment_count)
      `CHK("cfg_rst", 1'b0, config_reset)
      rd(STATUS_OFS, 8'h01);
      rd(CTRL_OFS, 8'h04);
      rd(VPROG_OFS, 8'h00);
      rd(MUX_OFS, 8'h00);
   endtask : chk_rst
   task results();
      if (n_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   always @(posedge sys_clk) begin
      rd_d <= reg_rd;
      if (rd_d) begin
         e_r = exp_q.pop_front();
         `CHK("rdata", e_r, reg_rdata)
      end
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      void'($urandom(1));
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (12) @(posedge sys_clk);
      chk_rst();
      for (int i = 0; i < 20; i++) begin
         v = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
         o = i == 0 ? 8'sh7f : i == 1 ? 8'sh80 : 8'($urandom);
         c = i < 2 ? 1'b1 : 1'($urandom);
         want_off <= o;
         wr(CTRL_OFS, {5'h0, c, 2'b01});
         wr(VPROG_OFS, v);
         repeat (3) @(posedge sys_clk);
         e = sat(v, c ? o : 8'sh00);
         `CHK("lcd_drive_voltage", e, lcd_drive_voltage)
         rd(TARGET_OFS, e);
         k = (int'(v) + int'(c ? o : 8'sh00)) != int'(e);
         rd(STATUS_OFS, {5'h0, 1'b1, k, 1'b1});
      end
      wr(CTRL_OFS, 8'h0d);
      repeat (2) @(posedge sys_clk);
      `CHK("disp", 1'b1, display_on)
      `CHK("gen", 1'b1, lcd_drive_voltage_gen_on)
      wr(CTRL_OFS, 8'h03);
      @(posedge sys_clk);
      `CHK("mult", 1'b1, pump_multiplier_select)
      wr(CTRL_OFS, 8'h02);
      repeat (2) @(posedge sys_clk);
      `CHK("pump", 1'b0, pump_on_bit)
      wr(CTRL_OFS, 8'h14);
      wr(VPROG_OFS, 8'h55);
      repeat (2) @(posedge sys_clk);
      `CHK("lcd_drive_voltage", 8'h00, lcd_drive_voltage)
      `CHK("gen", 1'b0, lcd_drive_voltage_gen_on)
      for (int i = 0; i < 6; i++) begin
         wr(MUX_OFS, 8'(i));
         @(posedge sys_clk);
         `CHK("bp", bp_tab[i > 4 ? 4 : i], backplane_count)
         `CHK("seg", i >= 4 ? 6'h2e : 6'h2c, segment_count)
         rd(GEOM_OFS, i >= 4 ? 8'h2e : 8'h2c);
      end
      rd(4'hf, 8'h00);
      wr(CTRL_OFS, 8'h0b);
      @(posedge sys_clk);
      reset_pin_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      `CHK("pump", 1'b0, pump_on_bit)
      `CHK("disp", 1'b0, display_on)
      `CHK("lcd_drive_voltage", 8'h00, lcd_drive_voltage)
      `CHK("cfg_rst", 1'b1, config_reset)
      reset_pin_n <= 1'b1;
      want_off <= 8'sh00;
      repeat (12) @(posedge sys_clk);
      chk_rst();
      wr(CTRL_OFS, 8'h03);
      wr(CTRL_OFS, 8'h00);
      repeat (3) @(posedge sys_clk);
      `CHK("pump", 1'b0, pump_on_bit)
      results();
   end
endmodule : tb_lcd_supply_reset_control
